// ===== hw/scbc_consts.vh
// Constants for the clock buffer serial control block
`ifndef SCBC_CONSTS_VH
`define SCBC_CONSTS_VH

`define SCBC_IDX_OUT_EN       8'h00
`define SCBC_IDX_MODE_AMP     8'h01
`define SCBC_IDX_SLEW         8'h02
`define SCBC_IDX_FREQ         8'h03
`define SCBC_NUM_REGS         4

`define SCBC_RST_OUT_EN       8'hff
`define SCBC_RST_MODE_AMP     8'h06
`define SCBC_RST_SLEW         8'hff
`define SCBC_RST_FREQ         8'hc7

// Writable bit masks; other bits are fixed reserved values
`define SCBC_WMASK_OUT_EN     8'h6a
`define SCBC_WMASK_MODE_AMP   8'h3b
`define SCBC_WMASK_SLEW       8'h6a
`define SCBC_WMASK_FREQ       8'h39

`define SCBC_BIT_OE3          6
`define SCBC_BIT_OE2          5
`define SCBC_BIT_OE1          3
`define SCBC_BIT_OE0          1
`define SCBC_BIT_PLL_SW       5
`define SCBC_BIT_FSEL_EN      5
`define SCBC_BIT_FB_SLEW      0

`define SCBC_PLL_LO_BW        2'h0
`define SCBC_PLL_BYPASS       2'h1
`define SCBC_PLL_HI_BW        2'h3
`define SCBC_FSEL_100M        2'h0

// Byte count reported at the start of a block read
`define SCBC_READ_COUNT       8'h04

// Target addresses per strap level
`define SCBC_ADDR_STRAP_LO    7'h6b
`define SCBC_ADDR_STRAP_MID   7'h6c
`define SCBC_ADDR_STRAP_HI    7'h6d

`endif

// ===== hw/scbc_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module scbc_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge sys_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          meta_ff[i] <= 1'b1;
          sync_ff[i] <= 1'b1;
        end
        else
        begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;
endmodule // scbc_sync

// ===== hw/scbc_ctrl.v
// Serial target interface and control registers of a clock fan-out buffer
`timescale 1ns/1ns
`include "scbc_consts.vh"
module scbc_ctrl
(
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire [1:0] target_addr_strap,
  input  wire [1:0] pll_mode_strap,
  input  wire [3:0] out_enable_pin_n,
  output reg  [3:0] clock_output_pair_run,
  output reg  [1:0] pll_mode_active,
  output reg  [1:0] amplitude_sel,
  output reg  [3:0] edge_rate_out,
  output reg        edge_rate_feedback,
  output reg  [1:0] rate_choice_active
);
  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  // Straps and enable pins share the synchroniser with the bus pins
  wire [9:0] pin_sync;
  wire       scl_s        = pin_sync[1];
  wire       sda_s        = pin_sync[0];
  wire [1:0] mode_strap_s = pin_sync[3:2];
  wire [1:0] addr_strap_s = pin_sync[5:4];
  wire [3:0] oen_pin_s    = pin_sync[9:6];

  scbc_sync #(.WIDTH(10)) u_sync
  (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({out_enable_pin_n, target_addr_strap, pll_mode_strap,
                scl_in, sda_in}),
    .sync_out (pin_sync)
  );

  reg scl_d_ff;
  reg sda_d_ff;
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  wire stop_c   = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // ****************************************************************
  // Strap capture, three cycles after reset release
  // ****************************************************************
  reg [1:0] strap_cnt_ff;
  reg [6:0] own_addr_ff;
  reg [1:0] pll_latch_ff;
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_cnt_ff <= 2'h0;
      own_addr_ff  <= `SCBC_ADDR_STRAP_LO;
      pll_latch_ff <= `SCBC_PLL_LO_BW;
    end
    else
    begin
      if (strap_cnt_ff != 2'h3)
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      // Wait until the strap levels have crossed the synchroniser
      if (strap_cnt_ff == 2'h2)
      begin
        // Strap code: 00 low, 01 middle, 1x high
        case (addr_strap_s)
          2'h0:    own_addr_ff <= `SCBC_ADDR_STRAP_LO;
          2'h1:    own_addr_ff <= `SCBC_ADDR_STRAP_MID;
          default: own_addr_ff <= `SCBC_ADDR_STRAP_HI;
        endcase
        case (mode_strap_s)
          2'h0:    pll_latch_ff <= `SCBC_PLL_LO_BW;
          2'h1:    pll_latch_ff <= `SCBC_PLL_BYPASS;
          default: pll_latch_ff <= `SCBC_PLL_HI_BW;
        endcase
      end
    end
  end

  // ****************************************************************
  // Serial target state machine
  // ****************************************************************
  localparam ST_IDLE  = 3'h0;
  localparam ST_RECV  = 3'h1;
  localparam ST_ACK   = 3'h2;
  localparam ST_SEND  = 3'h3;
  localparam ST_RACK  = 3'h4;
  localparam ST_WAIT  = 3'h5;

  // Phase of a received byte: address, index, count, data
  localparam PH_ADDR  = 2'h0;
  localparam PH_INDEX = 2'h1;
  localparam PH_COUNT = 2'h2;
  localparam PH_DATA  = 2'h3;

  localparam [7:0] READ_COUNT = `SCBC_READ_COUNT;

  reg [2:0] state_ff;
  reg [1:0] phase_ff;
  reg [7:0] shift_ff;
  reg [3:0] bitcnt_ff;
  reg [7:0] index_ff;
  reg       rd_first_ff;
  reg       sda_oe_ff;
  reg       load_pending_ff;
  reg [7:0] regs_ff [0:`SCBC_NUM_REGS-1];

  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};

  // Register read view: bits 7:6 of register 1 always show the latch
  reg [7:0] rd_data;
  always @*
  begin
    rd_data = 8'hff;
    if (index_ff < `SCBC_NUM_REGS)
      rd_data = regs_ff[index_ff[1:0]];
    if (index_ff == `SCBC_IDX_MODE_AMP)
      rd_data = {pll_latch_ff, regs_ff[1][5:0]};
  end

  reg [7:0] wmask;
  always @*
  begin
    case (index_ff)
      `SCBC_IDX_OUT_EN:   wmask = `SCBC_WMASK_OUT_EN;
      `SCBC_IDX_MODE_AMP: wmask = `SCBC_WMASK_MODE_AMP;
      `SCBC_IDX_SLEW:     wmask = `SCBC_WMASK_SLEW;
      `SCBC_IDX_FREQ:     wmask = `SCBC_WMASK_FREQ;
      default:            wmask = 8'h00;
    endcase
  end

  integer k;
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff    <= ST_IDLE;
      phase_ff    <= PH_ADDR;
      shift_ff    <= 8'h00;
      bitcnt_ff   <= 4'h0;
      index_ff    <= 8'h00;
      rd_first_ff <= 1'b0;
      sda_oe_ff   <= 1'b0;
      regs_ff[0]  <= `SCBC_RST_OUT_EN;
      regs_ff[1]  <= `SCBC_RST_MODE_AMP;
      regs_ff[2]  <= `SCBC_RST_SLEW;
      regs_ff[3]  <= `SCBC_RST_FREQ;
    end
    else if (stop_c)
    begin
      state_ff  <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end
    else if (start_c)
    begin
      // Repeated start keeps the index written earlier
      state_ff  <= ST_RECV;
      phase_ff  <= PH_ADDR;
      bitcnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          sda_oe_ff <= 1'b0;
        ST_RECV:
          if (scl_rise)
          begin
            shift_ff  <= rx_byte;
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'h7)
            begin
              state_ff  <= ST_ACK;
              bitcnt_ff <= 4'h0;
              case (phase_ff)
                PH_ADDR:
                  if (rx_byte[7:1] != own_addr_ff)
                    state_ff <= ST_WAIT;
                  else
                    rd_first_ff <= rx_byte[0];
                PH_INDEX:
                  index_ff <= rx_byte;
                PH_COUNT:
                  ;
                default:
                begin
                  // Store into consecutive registers
                  for (k = 0; k < `SCBC_NUM_REGS; k = k + 1)
                    if (index_ff == k)
                      regs_ff[k] <= (regs_ff[k] & ~wmask) |
                                    (rx_byte & wmask);
                end
              endcase
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            if (!sda_oe_ff)
              sda_oe_ff <= 1'b1;
            else
            begin
              sda_oe_ff <= 1'b0;
              if (phase_ff == PH_ADDR && rd_first_ff)
              begin
                // Count goes out before any register data
                state_ff <= ST_SEND;
                shift_ff <= `SCBC_READ_COUNT;
                sda_oe_ff <= ~READ_COUNT[7];
              end
              else
              begin
                state_ff <= ST_RECV;
                if (phase_ff == PH_DATA)
                  index_ff <= index_ff + 8'h1;
                else
                  phase_ff <= phase_ff + 2'h1;
              end
            end
          end
        ST_SEND:
          if (scl_fall)
          begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'h7)
            begin
              state_ff  <= ST_RACK;
              bitcnt_ff <= 4'h0;
              sda_oe_ff <= 1'b0;
            end
            else
            begin
              shift_ff  <= {shift_ff[6:0], 1'b0};
              sda_oe_ff <= ~shift_ff[6];
            end
          end
        ST_RACK:
          if (scl_rise)
          begin
            // A nack ends the read; wait for the stop
            if (sda_s)
              state_ff <= ST_WAIT;
            else if (rd_first_ff)
              rd_first_ff <= 1'b0;
            else
              index_ff <= index_ff + 8'h1;
          end
          else if (scl_fall && load_pending_ff)
          begin
            // Next byte's MSB goes out as the ack clock falls
            state_ff  <= ST_SEND;
            shift_ff  <= rd_data;
            sda_oe_ff <= ~rd_data[7];
          end
        ST_WAIT:
          sda_oe_ff <= 1'b0;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Host ack seen; held until the clock falls and the next byte loads
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      load_pending_ff <= 1'b0;
    else
      load_pending_ff <= (state_ff == ST_RACK) &&
                         (load_pending_ff || (scl_rise && !sda_s));
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_ff;

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  wire [3:0] oe_bits = {regs_ff[0][`SCBC_BIT_OE3], regs_ff[0][`SCBC_BIT_OE2],
                        regs_ff[0][`SCBC_BIT_OE1], regs_ff[0][`SCBC_BIT_OE0]};
  wire [3:0] slew_bits = {regs_ff[2][6], regs_ff[2][5],
                          regs_ff[2][3], regs_ff[2][1]};
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clock_output_pair_run <= 4'h0;
      pll_mode_active       <= `SCBC_PLL_LO_BW;
      amplitude_sel         <= 2'h2;
      edge_rate_out         <= 4'hf;
      edge_rate_feedback    <= 1'b1;
      rate_choice_active    <= `SCBC_FSEL_100M;
    end
    else
    begin
      // A zero enable bit forces low regardless of the pin
      clock_output_pair_run <= oe_bits & ~oen_pin_s;
      pll_mode_active <= regs_ff[1][`SCBC_BIT_PLL_SW] ?
                         regs_ff[1][4:3] : pll_latch_ff;
      amplitude_sel      <= regs_ff[1][1:0];
      edge_rate_out      <= slew_bits;
      edge_rate_feedback <= regs_ff[3][`SCBC_BIT_FB_SLEW];
      rate_choice_active <= regs_ff[3][`SCBC_BIT_FSEL_EN] ?
                            regs_ff[3][4:3] : `SCBC_FSEL_100M;
    end
  end

endmodule // scbc_ctrl

// ===== tb/scbc_ctrl_assertions.sv
// Concurrent checks on the ports of the clock buffer serial control block
`timescale 1ns/1ns
module scbc_chk
(
  input wire       sys_clk,
  input wire       sys_rst,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [1:0] pll_mode_strap,
  input wire [3:0] out_enable_pin_n,
  input wire [3:0] clock_output_pair_run,
  input wire [1:0] pll_mode_active,
  input wire [1:0] amplitude_sel,
  input wire [3:0] edge_rate_out,
  input wire       edge_rate_feedback,
  input wire [1:0] rate_choice_active
);
  // ************************************************************
  // Serial pin and register output relations
  // ************************************************************
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_open_drain_only: assert property (
    sda_out == 1'b0) else $error("data pin driven high");
  a_oe_moves_clock_low: assert property (
    $changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  a_oe_holds_clock_high: assert property (
    $rose(scl_in) |-> $stable(sda_oe) [*4]) else $error("data unstable");
  a_ack_full_bit: assert property (
    $rose(sda_oe) |-> sda_oe [*5]) else $error("pull-down too short");
  a_defaults_after_reset: assert property (
    $past(sys_rst) |-> amplitude_sel == 2'h2 && edge_rate_out == 4'hf
      && edge_rate_feedback && rate_choice_active == 2'h0)
    else $error("wrong output defaults after reset");
  a_pin_gates_output: assert property (
    out_enable_pin_n[0] [*5] |-> !clock_output_pair_run[0])
    else $error("output runs with its pin off");
  a_mode_from_strap: assert property (
    $past(sys_rst) |-> ##4 pll_mode_active ==
      (pll_mode_strap[1] ? 2'h3 : pll_mode_strap))
    else $error("mode not taken from strap");
  a_idle_bus_quiet: assert property (
    (scl_in && sda_in) [*8] |-> $stable(amplitude_sel)
      && $stable(edge_rate_out) && $stable(rate_choice_active))
    else $error("settings moved on idle bus");
endmodule // scbc_chk

bind scbc_ctrl scbc_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .pll_mode_strap(pll_mode_strap), .out_enable_pin_n(out_enable_pin_n),
  .clock_output_pair_run(clock_output_pair_run),
  .pll_mode_active(pll_mode_active), .amplitude_sel(amplitude_sel),
  .edge_rate_out(edge_rate_out), .edge_rate_feedback(edge_rate_feedback),
  .rate_choice_active(rate_choice_active));

// ===== tb/scbc_host.sv
// Behavioural serial bus host that drives block transfers
`timescale 1ns/1ns
module scbc_host
(
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  // ************************************************************
  // Bus primitives; both lines idle released, clock stands high
  // ************************************************************
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // 125 ns a bit runs at 8 MHz, far above the 400 kHz ceiling
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #30 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
    #35;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ar);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, ar);
  endtask

  // Serves as repeated start too, from a low clock
  task automatic start();
    sda_low = 1'b0;
    #30 scl = 1'b1;
    #30 sda_low = 1'b1;
    #30 scl = 1'b0;
    #35;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #30 scl = 1'b1;
    #30 sda_low = 1'b0;
    #65;
  endtask
endmodule // scbc_host

// ===== tb/test_smbus_clock_buffer_ctrl.sv
// Self-checking bench for the clock buffer serial control block
`timescale 1ns/1ns
`include "scbc_consts.vh"
module test_smbus_clock_buffer_ctrl;
  logic       sys_clk;
  logic       sys_rst;
  logic [3:0] oe_pin_n;
  logic [7:0] q;
  logic       ak;
  int         n_fail;
  int         compares;
  int         cyc = 0;
  wire        scl;
  wire        h_low;
  wire        sda_oe;
  wire        sda_out;
  wire [3:0]  run;
  wire [1:0]  mode;
  wire [1:0]  amp;
  wire [3:0]  slew;
  wire        fb;
  wire [1:0]  rate;
  // Pull-up: low only while some party pulls the line
  wire        sda = !(h_low || (sda_oe && !sda_out));
  localparam logic [7:0] WADR = {`SCBC_ADDR_STRAP_MID, 1'b0};

  scbc_host host (.scl(scl), .sda_low(h_low), .sda(sda));
  scbc_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .target_addr_strap(2'b01), .pll_mode_strap(2'b01),
    .out_enable_pin_n(oe_pin_n), .clock_output_pair_run(run),
    .pll_mode_active(mode), .amplitude_sel(amp), .edge_rate_out(slew),
    .edge_rate_feedback(fb), .rate_choice_active(rate));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(negedge sys_clk);
    #1;
  endtask

  task automatic outs(input logic [3:0] r, input logic [1:0] m,
    input logic [1:0] a, input logic [3:0] s, input logic f,
    input logic [1:0] c);
    chk({2'h0, run, mode}, {2'h0, r, m});
    chk({1'b0, amp, slew, fb}, {1'b0, a, s, f});
    chk({6'h0, rate}, {6'h0, c});
  endtask

  task automatic send(input logic [7:0] d);
    host.byte_io(d, 1'b1, q, ak);
    chk({7'h0, ak}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] idx, input int n,
                    input logic [31:0] dw);
    settle();
    host.start();
    send(WADR);
    send(idx);
    send(8'(n));
    for (int i = 0; i < n; i++)
      send(dw[31-8*i -: 8]);
    host.stop();
    settle();
  endtask

  task automatic rd(input logic [7:0] idx, input int n,
                    input logic [31:0] exp);
    settle();
    host.start();
    send(WADR);
    send(idx);
    host.start();
    send(WADR | 8'h01);
    host.byte_io(8'hff, 1'b0, q, ak);
    chk(q, `SCBC_READ_COUNT);
    for (int i = 0; i < n; i++)
    begin
      host.byte_io(8'hff, i == n - 1, q, ak);
      chk(q, exp[31-8*i -: 8]);
    end
    host.stop();
    settle();
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    settle();
    outs(4'hf, `SCBC_PLL_BYPASS, 2'h2, 4'hf, 1'b1, 2'h0);
    rd(`SCBC_IDX_OUT_EN, 4, 32'hff46_ffc7);
    @(negedge sys_clk) oe_pin_n = 4'h5;
    settle();
    outs(4'ha, `SCBC_PLL_BYPASS, 2'h2, 4'hf, 1'b1, 2'h0);
    @(negedge sys_clk) oe_pin_n = 4'h0;
    $display("test reset_values done");
  endtask

  task automatic t_write();
    wr(`SCBC_IDX_OUT_EN, 4, 32'h00ff_0000);
    outs(4'h0, `SCBC_PLL_HI_BW, 2'h3, 4'h0, 1'b0, 2'h0);
    rd(`SCBC_IDX_OUT_EN, 4, 32'h957f_95c6);
    $display("test block_write done");
  endtask

  task automatic t_codes();
    logic [1:0] pc [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++)
    begin
      wr(`SCBC_IDX_MODE_AMP, 1, {3'b001, pc[i], 1'b0, 2'(i), 24'h0});
      outs(4'h0, pc[i], 2'(i), 4'h0, 1'b0, 2'h0);
    end
    wr(`SCBC_IDX_MODE_AMP, 1, 32'h1a00_0000);
    outs(4'h0, `SCBC_PLL_BYPASS, 2'h2, 4'h0, 1'b0, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(`SCBC_IDX_FREQ, 1, {3'b001, 2'(i), 3'b001, 24'h0});
      outs(4'h0, `SCBC_PLL_BYPASS, 2'h2, 4'h0, 1'b1, 2'(i));
    end
    wr(`SCBC_IDX_FREQ, 1, 32'h1000_0000);
    outs(4'h0, `SCBC_PLL_BYPASS, 2'h2, 4'h0, 1'b0, 2'h0);
    $display("test mode_codes done");
  endtask

  task automatic t_nack();
    settle();
    host.start();
    host.byte_io({`SCBC_ADDR_STRAP_LO, 1'b0}, 1'b1, q, ak);
    chk({7'h0, ak}, 8'h01);
    host.stop();
    rd(`SCBC_IDX_SLEW, 2, 32'h95d6_0000);
    $display("test foreign_address done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    oe_pin_n = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_write();
    t_codes();
    t_nack();
    @(negedge sys_clk) sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    complete_run();
  end
endmodule // test_smbus_clock_buffer_ctrl
